/* dac_mode_pkg.sv */
// Constants for the external-filter / bitstream mode control block.
// Assumes a byte-wide register port with 7-bit register indices.
package dac_mode_pkg;
  // Register indices
  localparam logic [6:0] REG_FMT_FIR = 7'h12;
  localparam logic [6:0] REG_OUT_POL = 7'h13;
  localparam logic [6:0] REG_MODE_RATE = 7'h14;
  localparam logic [6:0] REG_ZERO_EN = 7'h15;
  localparam logic [6:0] REG_ZERO_FLG = 7'h16;
  // Field positions
  localparam int FMT_LSB = 4;
  localparam int FIR_LSB = 2;
  localparam int RATE_LSB = 0;
  localparam int EXT_BIT = 4;
  localparam int BS_BIT = 5;
  // Reset values
  localparam logic [7:0] RST_FMT_FIR = 8'h00;
  localparam logic [7:0] RST_OUT_POL = 8'h00;
  localparam logic [7:0] RST_MODE_RATE = 8'h00;
  localparam logic [7:0] RST_ZERO_EN = 8'h01;
  // Writable masks per mode: bits not in the mask are ignored
  localparam logic [7:0] EXT_MASK_18 = 8'h70;
  localparam logic [7:0] EXT_MASK_19 = 8'h95;
  localparam logic [7:0] EXT_MASK_20 = 8'h7F;
  localparam logic [7:0] EXT_MASK_21 = 8'h01;
  localparam logic [7:0] BS_MASK_18 = 8'h0C;
  localparam logic [7:0] BS_MASK_19 = 8'h90;
  localparam logic [7:0] BS_MASK_20 = 8'h6F;
  localparam logic [7:0] BS_MASK_21 = 8'h06;
  // Codes
  localparam logic [2:0] FMT_16 = 3'h0;
  localparam logic [2:0] FMT_20 = 3'h1;
  localparam logic [2:0] FMT_24 = 3'h2;
  localparam logic [1:0] RATE_X8 = 2'h0;
  localparam logic [1:0] RATE_X4 = 2'h1;
  localparam logic [1:0] RATE_X16 = 2'h2;
  localparam logic [1:0] FIR_FULL = 2'h0;
  localparam logic [1:0] FIR_HALF = 2'h1;
  localparam logic [1:0] FIR_QUART = 2'h3;
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] LEN_20 = 5'h14;
  localparam logic [4:0] LEN_24 = 5'h18;
  localparam logic [4:0] MULT_8 = 5'h08;
  localparam logic [4:0] MULT_4 = 5'h04;
  localparam logic [4:0] MULT_16 = 5'h10;
  localparam int UPPER_BITS = 6;
  localparam int LOWER_BITS = 18;
  localparam logic [6:0] ELEMENTS = 7'h42;
endpackage : dac_mode_pkg

/* dac_ext_filter_bitstream_ctrl.sv */
// Mode control, input capture and segmented conversion core.
// Assumes a decoded register port (index, strobe, byte data) and the
// external-filter word clock / bitstream bit clock arriving as pins.
`timescale 1ns/1ps
// How it works
// - Writes to bits disabled in the active mode are dropped.
// - Format field picks 16, 20 or 24-bit right-justified words.
// - Rate field picks modulator rate 8x, 4x or 16x word clock.
// - Overall oversampling equals filter ratio times modulator rate.
// - Writing bit 5 of mode register enters bitstream mode.
// - Bitstream bit set before data, else cascade detect blocks control port.
// - FIR response field selects one of four analog FIR responses.
// - Rate field sets FIR speed: full, half or quarter bit clock.
// - Word splits into 6 upper bits, inverted offset code, and 18 lower.
// - Lower bits feed a five-level third-order modulator.
// - One modulator level weighs one upper-code step.
// - Sum of up to 66 levels rotates elements before segments.
module dac_ext_filter_bitstream_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  input wire logic reg_wr,
  input wire logic [6:0] reg_idx,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic cmd_reject,
  // Zero flags from the zero detector
  input wire logic left_zero_flag,
  input wire logic right_zero_flag,
  // External filter interface
  input wire logic word_clock,
  input wire logic ser_bit_clk,
  input wire logic ser_data,
  // Bitstream interface
  input wire logic bitstream_bit_clock,
  input wire logic left_bitstream_in,
  input wire logic right_bitstream_in,
  // Mode status
  output logic ext_mode,
  output logic bs_mode,
  output logic [4:0] word_len,
  output logic [4:0] mod_mult,
  output logic [7:0] total_osr,
  output logic [1:0] fir_response,
  output logic [2:0] fir_div,
  output logic [1:0] bs_pair,
  output logic bs_pair_vld,
  // Conversion core
  output logic [23:0] word_out,
  output logic word_vld,
  output logic [65:0] seg_enable
);

  // Reset release through two flops
  // Assertion is immediate; release is clocked so no flop sees a runt edge
  logic [1:0] rst_sync_reg;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rst_sync_reg <= 2'b00;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  logic rst_n;
  assign rst_n = rst_sync_reg[1];

  // Pin synchronisers, three stages each; stage 0 read only by stage 1
  // Reset level matches the idle low level of every clock pin, so no false edge
  logic [2:0] wck_s, sck_s, sdat_s, bck_s, bl_s, br_s;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wck_s <= '0; sck_s <= '0; sdat_s <= '0;
      bck_s <= '0; bl_s <= '0; br_s <= '0;
    end else begin
      wck_s <= {wck_s[1:0], word_clock};
      sck_s <= {sck_s[1:0], ser_bit_clk};
      sdat_s <= {sdat_s[1:0], ser_data};
      bck_s <= {bck_s[1:0], bitstream_bit_clock};
      bl_s <= {bl_s[1:0], left_bitstream_in};
      br_s <= {br_s[1:0], right_bitstream_in};
    end
  end

  // Rising edge: second stage shows the new level while the third still holds the old one
  // The third stage holds the previous settled level, so a glitch sampled
  // once by the first stage still counts as an edge when it reaches the second
  function automatic logic rise(input logic [2:0] s);
    rise = s[1] & ~s[2];
  endfunction : rise

  // Register state
  logic [7:0] r18_reg, r19_reg, r20_reg, r21_reg;
  logic [7:0] r18_next, r19_next, r20_next, r21_next;
  logic bs_seen_reg, bs_seen_next;
  logic [7:0] m18, m19, m20, m21;

  // Masked update keeps disabled bits untouched
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] d,
                                       input logic [7:0] m);
    merge = (old & ~m) | (d & m);
  endfunction : merge

  // Register write path
  // Outside both special modes every bit is writable
  always_comb begin
    m18 = 8'hFF; m19 = 8'hFF; m20 = 8'hFF; m21 = 8'hFF;
    if (r20_reg[dac_mode_pkg::BS_BIT]) begin
      m18 = dac_mode_pkg::BS_MASK_18; m19 = dac_mode_pkg::BS_MASK_19;
      m20 = dac_mode_pkg::BS_MASK_20; m21 = dac_mode_pkg::BS_MASK_21;
    end else if (r20_reg[dac_mode_pkg::EXT_BIT]) begin
      m18 = dac_mode_pkg::EXT_MASK_18; m19 = dac_mode_pkg::EXT_MASK_19;
      m20 = dac_mode_pkg::EXT_MASK_20; m21 = dac_mode_pkg::EXT_MASK_21;
    end
    r18_next = r18_reg;
    r19_next = r19_reg;
    r20_next = r20_reg;
    r21_next = r21_reg;
    // Bitstream activity before the mode bit is taken as cascade mode
    bs_seen_next = bs_seen_reg | (rise(bck_s) & ~r20_reg[dac_mode_pkg::BS_BIT]);
    // Refusal is sticky until reset; a later mode write cannot undo it
    if (reg_wr && !bs_seen_reg) begin
      unique case (reg_idx)
        dac_mode_pkg::REG_FMT_FIR: r18_next = merge(r18_reg, reg_wdata, m18);
        dac_mode_pkg::REG_OUT_POL: r19_next = merge(r19_reg, reg_wdata, m19);
        dac_mode_pkg::REG_MODE_RATE: r20_next = merge(r20_reg, reg_wdata, m20);
        dac_mode_pkg::REG_ZERO_EN: r21_next = merge(r21_reg, reg_wdata, m21);
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r18_reg <= dac_mode_pkg::RST_FMT_FIR;
      r19_reg <= dac_mode_pkg::RST_OUT_POL;
      r20_reg <= dac_mode_pkg::RST_MODE_RATE;
      r21_reg <= dac_mode_pkg::RST_ZERO_EN;
      bs_seen_reg <= 1'b0;
    end else begin
      r18_reg <= r18_next;
      r19_reg <= r19_next;
      r20_reg <= r20_next;
      r21_reg <= r21_next;
      bs_seen_reg <= bs_seen_next;
    end
  end

  // Decoded configuration
  logic bs_m, ext_m;
  logic [2:0] input_format_select;
  logic [1:0] modulator_rate_select, fir_response_select;
  logic [4:0] len_d, mult_d;
  logic [2:0] div_d;
  logic [7:0] rd_d;
  always_comb begin
    bs_m = r20_reg[dac_mode_pkg::BS_BIT];
    ext_m = r20_reg[dac_mode_pkg::EXT_BIT] & ~bs_m;
    input_format_select = r18_reg[dac_mode_pkg::FMT_LSB +: 3];
    modulator_rate_select = r20_reg[dac_mode_pkg::RATE_LSB +: 2];
    fir_response_select = r18_reg[dac_mode_pkg::FIR_LSB +: 2];
    // Reserved codes fall back to the default so no mode is undefined
    unique case (input_format_select)
      dac_mode_pkg::FMT_20: len_d = dac_mode_pkg::LEN_20;
      dac_mode_pkg::FMT_24: len_d = dac_mode_pkg::LEN_24;
      default: len_d = dac_mode_pkg::LEN_16;
    endcase
    unique case (modulator_rate_select)
      dac_mode_pkg::RATE_X4: mult_d = dac_mode_pkg::MULT_4;
      dac_mode_pkg::RATE_X16: mult_d = dac_mode_pkg::MULT_16;
      default: mult_d = dac_mode_pkg::MULT_8;
    endcase
    unique case (modulator_rate_select)
      dac_mode_pkg::FIR_HALF: div_d = 3'h2;
      dac_mode_pkg::FIR_QUART: div_d = 3'h4;
      default: div_d = 3'h1;
    endcase
    unique case (reg_idx)
      dac_mode_pkg::REG_FMT_FIR: rd_d = r18_reg;
      dac_mode_pkg::REG_OUT_POL: rd_d = r19_reg;
      dac_mode_pkg::REG_MODE_RATE: rd_d = r20_reg;
      dac_mode_pkg::REG_ZERO_EN: rd_d = r21_reg;
      dac_mode_pkg::REG_ZERO_FLG: rd_d = {6'h00, right_zero_flag, left_zero_flag};
      default: rd_d = 8'h00;
    endcase
  end

  // External-filter word capture: shift on bit clock, latch on word clock
  // Only the last 24 bits are kept; longer frames lose their oldest bits
  logic [23:0] sh_reg, sh_next, word_reg, word_next;
  logic wv_next;
  always_comb begin
    sh_next = sh_reg;
    word_next = word_reg;
    wv_next = 1'b0;
    if (ext_m && rise(sck_s)) sh_next = {sh_reg[22:0], sdat_s[2]};
    if (ext_m && rise(wck_s)) begin
      // Right-justified: keep the last word_len bits, left-aligned with zero fill
      unique case (len_d)
        dac_mode_pkg::LEN_20: word_next = {{4{sh_reg[19]}}, sh_reg[19:0]} << 4;
        dac_mode_pkg::LEN_24: word_next = sh_reg;
        default: word_next = {sh_reg[15:0], 8'h00};
      endcase
      wv_next = 1'b1;
    end
  end

  // Bitstream pair capture, divided by the FIR speed setting
  // Dividing here keeps one sample per FIR tick at the slower speeds
  logic [1:0] pair_reg, pair_next, div_reg, div_next;
  logic pv_next;
  always_comb begin
    pair_next = pair_reg;
    div_next = div_reg;
    pv_next = 1'b0;
    if (bs_m && rise(bck_s)) begin
      div_next = (div_reg == 2'(div_d - 3'h1)) ? 2'h0 : div_reg + 2'h1;
      if (div_reg == 2'h0) begin
        pair_next = {bl_s[2], br_s[2]};
        pv_next = 1'b1;
      end
    end
  end

  // Segment core: upper code plus five-level modulator, rotated elements
  logic [5:0] inverted_offset_code;
  logic [17:0] lower;
  logic signed [21:0] i1_reg, i2_reg, i3_reg, i1_next, i2_next, i3_next;
  logic signed [21:0] fb;
  logic [2:0] lvl;
  logic [6:0] sum_lvl, ptr_reg, ptr_next;
  logic [131:0] dbl;
  logic [65:0] therm, seg_next;
  always_comb begin
    // Offset binary flips the sign bit; inverting it gives the upper code
    inverted_offset_code = ~(~word_reg[23:18]);
    inverted_offset_code = {~inverted_offset_code[5], inverted_offset_code[4:0]} ^ 6'h3F;
    lower = word_reg[dac_mode_pkg::LOWER_BITS-1:0];
    i1_next = i1_reg;
    i2_next = i2_reg;
    i3_next = i3_reg;
    // Quantise third integrator into five levels 0..4
    // Thresholds sit one level step apart, matching the upper-code step
    if (i3_reg >= 22'sd196608) lvl = 3'h4;
    else if (i3_reg >= 22'sd131072) lvl = 3'h3;
    else if (i3_reg >= 22'sd65536) lvl = 3'h2;
    else if (i3_reg >= 22'sd0) lvl = 3'h1;
    else lvl = 3'h0;
    fb = 22'(lvl) <<< 16;
    // Integrators step once per captured word; between words they hold
    if (word_vld) begin
      i1_next = i1_reg + 22'(lower >> 2) - fb;
      i2_next = i2_reg + i1_reg - fb;
      i3_next = i3_reg + i2_reg - fb;
    end
    // One modulator level equals one upper-code step
    // Capped at the element count: code 63 plus level 4 would overrun the ring
    sum_lvl = (7'(inverted_offset_code) + 7'(lvl) > dac_mode_pkg::ELEMENTS) ? dac_mode_pkg::ELEMENTS :
              7'(inverted_offset_code) + 7'(lvl);
    therm = '0;
    for (int k = 0; k < 66; k++) therm[k] = (7'(k) < sum_lvl);
    dbl = {therm, therm} << ptr_reg;
    seg_next = dbl[131:66] | dbl[65:0];
    ptr_next = ptr_reg;
    // Eight-bit sum so the wrap test cannot overflow
    if (word_vld) begin
      ptr_next = (8'(ptr_reg) + 8'(sum_lvl) >= 8'(dac_mode_pkg::ELEMENTS)) ?
                 7'(ptr_reg + sum_lvl - dac_mode_pkg::ELEMENTS) : 7'(ptr_reg + sum_lvl);
    end
  end

  // Datapath and output registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_reg <= '0; word_reg <= '0; word_vld <= 1'b0;
      pair_reg <= '0; div_reg <= '0; bs_pair_vld <= 1'b0;
      i1_reg <= '0; i2_reg <= '0; i3_reg <= '0; ptr_reg <= '0;
      seg_enable <= '0; reg_rdata <= '0; cmd_reject <= 1'b0;
      ext_mode <= 1'b0; bs_mode <= 1'b0; word_len <= dac_mode_pkg::LEN_16;
      // Rate product at reset matches the default modulator rate
      mod_mult <= dac_mode_pkg::MULT_8; total_osr <= {dac_mode_pkg::MULT_8, 3'h0};
      fir_response <= '0; fir_div <= 3'h1; bs_pair <= '0; word_out <= '0;
    end else begin
      sh_reg <= sh_next; word_reg <= word_next; word_vld <= wv_next;
      pair_reg <= pair_next; div_reg <= div_next; bs_pair_vld <= pv_next;
      i1_reg <= i1_next; i2_reg <= i2_next; i3_reg <= i3_next; ptr_reg <= ptr_next;
      seg_enable <= seg_next; reg_rdata <= rd_d; cmd_reject <= bs_seen_reg;
      ext_mode <= ext_m; bs_mode <= bs_m; word_len <= len_d; mod_mult <= mult_d;
      // Filter ratio assumed 8x, the usual word-clock multiple
      total_osr <= {mult_d, 3'h0};
      fir_response <= fir_response_select; fir_div <= div_d;
      // Word output follows the strobe so both show in one cycle
      bs_pair <= pair_next; word_out <= word_next;
    end
  end

endmodule : dac_ext_filter_bitstream_ctrl

/* dac_ctrl_sva.sv */
// Port-level checks for the mode control and conversion block.
// Bound to the top module; sees only its ports.
`timescale 1ns/1ps
module dac_ctrl_sva (
  // Clock, reset, register port
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic [6:0] reg_idx,
  input wire logic [7:0] reg_wdata,
  // Status outputs
  input wire logic cmd_reject,
  input wire logic ext_mode,
  input wire logic bs_mode,
  input wire logic [4:0] word_len,
  input wire logic [4:0] mod_mult,
  input wire logic [7:0] total_osr,
  input wire logic [2:0] fir_div,
  input wire logic word_vld,
  input wire logic bs_pair_vld
);
  // One domain, so clock and disable are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Rate products and legal decoded values
  chk_osr_product: assert property (total_osr == {mod_mult, 3'h0})
    else $error("total rate is not eight times the modulator rate");
  chk_len_codes: assert property (word_len inside {5'h10, 5'h14, 5'h18})
    else $error("word length outside 16, 20, 24");
  chk_mult_codes: assert property (mod_mult inside {5'h04, 5'h08, 5'h10})
    else $error("modulator rate outside 4, 8, 16");
  chk_div_codes: assert property (fir_div inside {3'h1, 3'h2, 3'h4})
    else $error("fir divider outside 1, 2, 4");
  // Mode entry, exclusion and hold
  chk_bs_entry: assert property (reg_wr && reg_idx == 7'h14 && reg_wdata[5] && !cmd_reject
    |-> ##2 (bs_mode && !ext_mode)) else $error("bitstream mode not entered after write");
  chk_mode_hold: assert property (!reg_wr [*2] |=> $stable(bs_mode) && $stable(ext_mode))
    else $error("mode changed without a write");
  chk_reject_sticky: assert property (cmd_reject |=> cmd_reject)
    else $error("write refusal dropped before reset");
  // Data strobes are single cycle
  chk_word_pulse: assert property (word_vld |=> !word_vld)
    else $error("word strobe longer than one cycle");
  chk_pair_pulse: assert property (bs_pair_vld |=> !bs_pair_vld)
    else $error("bit pair strobe longer than one cycle");
endmodule : dac_ctrl_sva

bind dac_ext_filter_bitstream_ctrl dac_ctrl_sva i_dac_ctrl_sva (
  .sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
  .cmd_reject(cmd_reject), .ext_mode(ext_mode), .bs_mode(bs_mode), .word_len(word_len),
  .mod_mult(mod_mult), .total_osr(total_osr), .fir_div(fir_div), .word_vld(word_vld),
  .bs_pair_vld(bs_pair_vld)
);

/* dac_source_model.sv */
// Far-side source: bitstream decoder and external interpolation filter.
// Assumes the bench starts each stream by level or pulse.
`timescale 1ns/1ps
module dac_source_model (
  // Control from the bench
  input wire logic sys_clk,
  input wire logic bs_run,
  input wire logic ext_go,
  input wire logic [23:0] word,
  // Bitstream pins
  output logic bitstream_bit_clock,
  output logic left_bitstream_in,
  output logic right_bitstream_in,
  // External filter pins
  output logic word_clock,
  output logic ser_bit_clk,
  output logic ser_data
);
  // 80 ns bit clock only inside a run; data keeps flipping when idle
  initial begin
    bitstream_bit_clock = 1'b0;
    left_bitstream_in = 1'b0;
    right_bitstream_in = 1'b1;
    #3;
    forever begin
      #40;
      bitstream_bit_clock = bs_run ? ~bitstream_bit_clock : 1'b0;
      if (!bitstream_bit_clock) begin
        left_bitstream_in = ~left_bitstream_in;
        right_bitstream_in = ~left_bitstream_in;
      end
    end
  end
  // Word pins idle low
  initial begin
    word_clock = 1'b0;
    ser_bit_clk = 1'b0;
    ser_data = 1'b0;
  end
  // MSB first, then word clock; all timed from sys_clk
  // One word per 200 sys_clk: an 8x filter puts fs near 62 kHz, below 100 kHz
  always @(posedge ext_go) begin
    for (int i = 23; i >= 0; i--) begin
      ser_data <= word[i];
      repeat (4) @(posedge sys_clk);
      ser_bit_clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ser_bit_clk <= 1'b0;
    end
    ser_data <= ~word[0];
    word_clock <= 1'b1;
    repeat (8) @(posedge sys_clk);
    word_clock <= 1'b0;
  end
endmodule : dac_source_model

/* dac_ext_filter_bitstream_ctrl_tb_top.sv */
// Self-checking bench for the mode control block and its source model.
// Assumes writes land two edges before reads or status show them.
`timescale 1ns/1ps
module dac_ext_filter_bitstream_ctrl_tb_top;
  logic sys_clk, rst_b, reg_wr, left_zero_flag, right_zero_flag, bs_run, ext_go;
  logic cmd_reject, ext_mode, bs_mode, bs_pair_vld, word_vld, word_clock, ser_bit_clk, ser_data;
  logic bitstream_bit_clock, left_bitstream_in, right_bitstream_in;
  logic [6:0] reg_idx;
  logic [7:0] reg_wdata, reg_rdata, total_osr;
  logic [4:0] word_len, mod_mult;
  logic [2:0] fir_div;
  logic [1:0] fir_response, bs_pair;
  logic [23:0] sent, word_out;
  logic [65:0] seg_enable;
  int failures = 0;
  int check_count = 0;
  // Block and far side
  dac_ext_filter_bitstream_ctrl i_dac_ext_filter_bitstream_ctrl (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .cmd_reject(cmd_reject), .left_zero_flag(left_zero_flag),
    .right_zero_flag(right_zero_flag), .word_clock(word_clock), .ser_bit_clk(ser_bit_clk),
    .ser_data(ser_data), .bitstream_bit_clock(bitstream_bit_clock),
    .left_bitstream_in(left_bitstream_in), .right_bitstream_in(right_bitstream_in),
    .ext_mode(ext_mode), .bs_mode(bs_mode), .word_len(word_len), .mod_mult(mod_mult),
    .total_osr(total_osr), .fir_response(fir_response), .fir_div(fir_div), .bs_pair(bs_pair),
    .bs_pair_vld(bs_pair_vld), .word_out(word_out), .word_vld(word_vld), .seg_enable(seg_enable));
  dac_source_model i_dac_source_model (
    .sys_clk(sys_clk), .bs_run(bs_run), .ext_go(ext_go), .word(sent),
    .bitstream_bit_clock(bitstream_bit_clock), .left_bitstream_in(left_bitstream_in),
    .right_bitstream_in(right_bitstream_in), .word_clock(word_clock),
    .ser_bit_clk(ser_bit_clk), .ser_data(ser_data));
  // 100 MHz clock, far above 256 fs for the word rate used here
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  task automatic do_reset;
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask : do_reset
  // Write pulse, then wait until status shows it
  task automatic wr(input logic [6:0] idx, input logic [7:0] data);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_idx <= idx;
    reg_wdata <= data;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : wr
  task automatic rd(input logic [6:0] idx, input logic [7:0] mask, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_idx <= idx;
    repeat (2) @(posedge sys_clk);
    #1;
    check("reg_rdata", reg_rdata & mask, exp & mask);
  endtask : rd
  // Bounded wait for a data strobe; running out ends the run
  task automatic wait_vld(input bit bs);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while ((bs ? bs_pair_vld : word_vld) !== 1'b1 && n < 1000);
    check("strobe wait", n < 1000, 1);
    if (n >= 1000) conclude();
  endtask : wait_vld
  task automatic t_reset;
    rd(7'h12, 8'hff, 8'h00);
    rd(7'h14, 8'hff, 8'h00);
    rd(7'h15, 8'hff, 8'h01);
    rd(7'h16, 8'h03, 8'h02);
    check("word_len", word_len, 5'h10);
    check("mod_mult", mod_mult, 5'h08);
    check("fir_div", fir_div, 3'h1);
    // Zero word: upper code 31 plus one modulator level at idle integrators
    check("seg_enable ones", $countones(seg_enable), 32);
    check("seg_enable low", seg_enable[31:0], 32'hffff_ffff);
    $display("test reset done");
  endtask : t_reset
  task automatic t_ext;
    logic [4:0] mult [4];
    mult = '{5'h08, 5'h04, 5'h10, 5'h08};
    wr(7'h14, 8'h10);
    check("modes", {bs_mode, ext_mode}, 2'b01);
    for (int c = 0; c < 4; c++) begin
      wr(7'h14, 8'h10 | c[7:0]);
      check("mod_mult", mod_mult, mult[c]);
      check("total_osr", total_osr, {mult[c], 3'h0});
    end
    for (int c = 0; c < 8; c++) begin
      wr(7'h12, {1'b0, c[2:0], 4'h0});
      check("word_len", word_len, c == 1 ? 5'h14 : c == 2 ? 5'h18 : 5'h10);
    end
    wr(7'h12, 8'hff);
    rd(7'h12, 8'hff, 8'h70);
    wr(7'h14, 8'h91);
    wr(7'h10, 8'hff);
    rd(7'h14, 8'hff, 8'h11);
    wr(7'h12, 8'h20);
    sent = 24'h3c_96a5;
    ext_go <= 1'b1;
    wait_vld(1'b0);
    ext_go <= 1'b0;
    check("word_out", word_out, sent);
    $display("test external filter done");
  endtask : t_ext
  task automatic t_bits;
    logic [2:0] div [4];
    div = '{3'h1, 3'h2, 3'h1, 3'h4};
    for (int c = 0; c < 4; c++) begin
      wr(7'h14, c[7:0]);
      wr(7'h14, 8'h20 | c[7:0]);
      check("modes", {bs_mode, ext_mode}, 2'b10);
      check("fir_div", fir_div, div[c]);
      wr(7'h12, {4'h2, c[1:0], 2'h0});
      check("fir_response", fir_response, c[1:0]);
    end
    wr(7'h12, 8'hff);
    rd(7'h12, 8'hff, 8'h2c);
    wr(7'h14, 8'h20);
    bs_run <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wait_vld(1'b1);
      check("bs_pair", ^bs_pair, 1'b1);
    end
    bs_run <= 1'b0;
    check("cmd_reject", cmd_reject, 1'b0);
    $display("test bitstream done");
  endtask : t_bits
  task automatic t_reject;
    do_reset();
    bs_run <= 1'b1;
    repeat (40) @(posedge sys_clk);
    bs_run <= 1'b0;
    repeat (10) @(posedge sys_clk);
    check("cmd_reject", cmd_reject, 1'b1);
    wr(7'h14, 8'h20);
    rd(7'h14, 8'hff, 8'h00);
    do_reset();
    check("cmd_reject", cmd_reject, 1'b0);
    $display("test refusal done");
  endtask : t_reject
  // Main sequence
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_idx = 7'h12;
    reg_wdata = 8'h00;
    left_zero_flag = 1'b0;
    right_zero_flag = 1'b1;
    bs_run = 1'b0;
    ext_go = 1'b0;
    sent = 24'h0;
    do_reset();
    t_reset();
    t_ext();
    t_bits();
    t_reject();
    conclude();
  end
endmodule : dac_ext_filter_bitstream_ctrl_tb_top
